// >>> rtl/ident_csr_bank.sv
// Machine identification control registers of one hart.
// Contract
// - Legal-only field stores minimal bits yet reads full legal encoding.
// - Unsupported write to legal-only field may raise illegal instruction.
// - Read after illegal write is a deterministic function of it.
// - Field reads legal after legal write or reset.
// - Any-write field accepts any value, always reads legal.
// - Unsupported value in any-write field never raises exception.
// - Same illegal value always yields same legal read value.
// - Reset enters highest privilege mode.
// - Highest mode may access all lower-level control registers.
// - ISA report is read-only, full width, readable, may be zero.
// - Width code top two bits, reserved span, bitmap bits 25..0.
// - Width code 1, 2, 3 for 32, 64, 128 bits.
// - Width code reports the widest supported base.
// - Bitmap bit 0 is A through bit 25 is Z.
// - I set for full base, E set for embedded base.
// - H, S, U set exactly when those modes exist.
// - X set when any non-standard extension exists.
// - G set means further standard extensions exist.
// - Reserved bitmap letters read as zero.
// - Manufacturer register read-only, full width, zero if non-commercial.
// - Writes to reserved ignored span change nothing.
`timescale 1ns/1ps
`include "ident_csr_params.svh"

module ident_csr_bank #(
  parameter logic            HAS_USER     = 1'b1,
  parameter logic            HAS_SUPER    = 1'b0,
  parameter logic            HAS_HYPER    = 1'b0,
  parameter logic            EMBEDDED     = 1'b0,
  parameter logic            HAS_NONSTD   = 1'b0,
  parameter logic            HAS_MORE_STD = 1'b0,
  parameter logic [25:0]     STD_EXT      = 26'h0001105
) (
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    csr_req_i,
  input  wire logic [`ADDR_W-1:0]      csr_addr_i,
  input  wire ident_csr_pkg::csr_op_t  csr_op_i,
  input  wire logic [`NRW-1:0]         csr_wdata_i,
  input  wire ident_csr_pkg::priv_t    cur_priv_i,
  output logic      [`NRW-1:0]         csr_rdata_o,
  output logic                         csr_illegal_o,
  output ident_csr_pkg::priv_t         reset_priv_o
);

  // ****************************************************************
  // ISA report value
  // ****************************************************************
  logic [`EXT_W-1:0] ext_map;
  logic [`NRW-1:0]   isa_report;

  always_comb begin
    ext_map = STD_EXT & `EXT_OTHER_STD;
    ext_map[`EXT_BIT_I] = ~EMBEDDED;
    ext_map[`EXT_BIT_E] = EMBEDDED;
    ext_map[`EXT_BIT_H] = HAS_HYPER;
    ext_map[`EXT_BIT_S] = HAS_SUPER;
    ext_map[`EXT_BIT_U] = HAS_USER;
    ext_map[`EXT_BIT_X] = HAS_NONSTD;
    ext_map[`EXT_BIT_G] = HAS_MORE_STD;
    ext_map = ext_map & ~`EXT_RESERVED;
    isa_report = '0;
    // Only a 32-bit base exists here, so it is also the widest.
    isa_report[`WIDTH_CODE_HI:`WIDTH_CODE_LO] = `WIDTH_CODE_32;
    isa_report[`EXT_HI:0] = ext_map;
  end

  // ****************************************************************
  // Status register with a legal-only previous-privilege field
  // ****************************************************************
  logic [`NRW-1:0] status_new;
  logic [1:0]      pp_rd;
  logic            status_wr;
  logic [`NRW-1:0] scratch;
  logic [`NRW-1:0] next_scratch;
  logic [`NRW-1:0] old_val;
  logic [`NRW-1:0] new_val;
  logic            is_write;

  assign is_write  = csr_req_i && (csr_op_i != ident_csr_pkg::OP_CLEAR ||
                     csr_wdata_i != '0) && !csr_illegal_o;
  assign status_wr = is_write && csr_addr_i == `ADDR_STATUS_M;

  legal_pp_field u_pp (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .wr_en_i    (status_wr),
    .wr_val_i   (new_val[`PP_HI:`PP_LO]),
    .rd_val_o   (pp_rd)
  );

  // ****************************************************************
  // Access decode and read-modify-write
  // ****************************************************************
  logic known_addr;
  logic read_only;
  logic priv_ok;

  always_comb begin
    old_val = '0;
    status_new = '0;
    status_new[`PP_HI:`PP_LO] = pp_rd;
    case (csr_addr_i)
      `ADDR_ISA_REPORT: old_val = isa_report;
      `ADDR_MFR_ID:     old_val = `MFR_ID_VALUE;
      `ADDR_STATUS_M:   old_val = status_new;
      `ADDR_SCRATCH_M:  old_val = scratch;
      default:          old_val = '0;
    endcase
  end

  always_comb begin
    case (csr_op_i)
      ident_csr_pkg::OP_SET:   new_val = old_val | csr_wdata_i;
      ident_csr_pkg::OP_CLEAR: new_val = old_val & ~csr_wdata_i;
      default:                 new_val = csr_wdata_i;
    endcase
  end

  assign known_addr = csr_addr_i == `ADDR_ISA_REPORT ||
                      csr_addr_i == `ADDR_MFR_ID ||
                      csr_addr_i == `ADDR_STATUS_M ||
                      csr_addr_i == `ADDR_SCRATCH_M;
  assign read_only  = csr_addr_i == `ADDR_MFR_ID;
  // Highest mode passes any privilege check for lower registers.
  assign priv_ok    = cur_priv_i == ident_csr_pkg::PRIV_M ||
                      csr_addr_i[`ADDR_PRIV_HI:`ADDR_PRIV_LO] <= cur_priv_i;

  // Writes to the ISA report are dropped without fault: it holds only
  // hardwired and reserved bits. The unsupported PP encodings are stored
  // as their high bit rather than trapped, so no exception is needed.
  always_comb begin
    csr_illegal_o = 1'b0;
    if (csr_req_i) begin
      if (!known_addr || !priv_ok) begin
        csr_illegal_o = 1'b1;
      end else if (read_only && csr_op_i == ident_csr_pkg::OP_WRITE) begin
        csr_illegal_o = 1'b1;
      end
    end
  end

  always_comb begin
    next_scratch = scratch;
    if (is_write && csr_addr_i == `ADDR_SCRATCH_M) begin
      next_scratch = new_val;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scratch     <= '0;
      csr_rdata_o <= '0;
    end else begin
      scratch     <= next_scratch;
      csr_rdata_o <= (csr_req_i && !csr_illegal_o) ? old_val : '0;
    end
  end

  assign reset_priv_o = ident_csr_pkg::PRIV_M;

endmodule : ident_csr_bank

// >>> rtl/ident_csr_params.svh
// Constants for the machine identification control registers.
`ifndef IDENT_CSR_PARAMS_SVH
`define IDENT_CSR_PARAMS_SVH

// ****************************************************************
// Register numbers and widths
// ****************************************************************
`define NRW              32
`define ADDR_W           12
`define ADDR_ISA_REPORT  12'h301
`define ADDR_MFR_ID      12'hF11
`define ADDR_SCRATCH_M   12'h340
`define ADDR_STATUS_M    12'h300
`define ADDR_PRIV_HI     9
`define ADDR_PRIV_LO     8

// ****************************************************************
// Fields of the ISA report register
// ****************************************************************
`define WIDTH_CODE_HI    31
`define WIDTH_CODE_LO    30
`define EXT_HI           25
`define EXT_W            26
`define WIDTH_CODE_32    2'h1
`define WIDTH_CODE_64    2'h2
`define WIDTH_CODE_128   2'h3
`define EXT_BIT_E        4
`define EXT_BIT_G        6
`define EXT_BIT_H        7
`define EXT_BIT_I        8
`define EXT_BIT_S        18
`define EXT_BIT_U        20
`define EXT_BIT_X        23
// Letters J K O R W Y Z: reserved, always read as zero.
`define EXT_RESERVED     26'h3424600
// Letters A B C D F L M N P Q T V: passed through from the parameter.
`define EXT_OTHER_STD    26'h029B82F

// ****************************************************************
// Previous-privilege field of the status register
// ****************************************************************
`define PP_HI            12
`define PP_LO            11
`define PP_M             2'h3
`define PP_U             2'h0
`define PP_STORE_BIT     1
`define PP_RESET_BIT     1'h1

// Vendor code: arbitrary neutral value, zero marks non-commercial.
`define MFR_ID_VALUE     32'h0000_0000

`endif

// >>> rtl/ident_csr_pkg.sv
// Types shared by the identification register block.
package ident_csr_pkg;

  typedef enum logic [1:0] {
    PRIV_U = 2'b00,
    PRIV_S = 2'b01,
    PRIV_H = 2'b10,
    PRIV_M = 2'b11
  } priv_t;

  typedef enum logic [1:0] {
    OP_WRITE = 2'b01,
    OP_SET   = 2'b10,
    OP_CLEAR = 2'b11
  } csr_op_t;

endpackage : ident_csr_pkg

// >>> rtl/legal_pp_field.sv
// Previous-privilege field held with one storage bit.
`timescale 1ns/1ps
`include "ident_csr_params.svh"

module legal_pp_field (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       wr_en_i,
  input  wire logic [1:0] wr_val_i,
  output logic      [1:0] rd_val_o
);

  logic stored_bit;
  logic next_bit;

  // Only M and U are supported, so one bit tells them apart.
  always_comb begin
    next_bit = stored_bit;
    if (wr_en_i) begin
      next_bit = wr_val_i[`PP_STORE_BIT];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stored_bit <= `PP_RESET_BIT;
    end else begin
      stored_bit <= next_bit;
    end
  end

  // Full two-bit encoding returned for every stored value.
  assign rd_val_o = stored_bit ? `PP_M : `PP_U;

endmodule : legal_pp_field

// >>> verification/ident_csr_bank_properties.sv
// Concurrent checks on the identification register ports.
`timescale 1ns/1ps
`include "ident_csr_params.svh"

module ident_csr_bank_properties (
  input wire logic                   core_clk_i,
  input wire logic                   rst_i,
  input wire logic                   csr_req_i,
  input wire logic [`ADDR_W-1:0]     csr_addr_i,
  input wire ident_csr_pkg::csr_op_t csr_op_i,
  input wire logic [`NRW-1:0]        csr_wdata_i,
  input wire ident_csr_pkg::priv_t   cur_priv_i,
  input wire logic [`NRW-1:0]        csr_rdata_o,
  input wire logic                   csr_illegal_o,
  input wire ident_csr_pkg::priv_t   reset_priv_o
);
  // ****************************************************************
  // Port relations
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire pm  = cur_priv_i == ident_csr_pkg::PRIV_M;
  wire isa = csr_req_i && csr_addr_i == `ADDR_ISA_REPORT && pm;
  wire mfr = csr_req_i && csr_addr_i == `ADDR_MFR_ID;
  wire pp  = csr_req_i && csr_addr_i == `ADDR_STATUS_M && pm;

  property p_reset_priv; reset_priv_o == ident_csr_pkg::PRIV_M; endproperty
  a_reset_priv: assert property (p_reset_priv) else $error("reset priv");
  property p_isa_code; isa |=> csr_rdata_o[31:30] == `WIDTH_CODE_32;
  endproperty
  a_isa_code: assert property (p_isa_code) else $error("width code");
  property p_isa_gap; isa |=> csr_rdata_o[29:26] == 4'h0; endproperty
  a_isa_gap: assert property (p_isa_gap) else $error("isa gap");
  property p_ext_rsv; isa |=> (csr_rdata_o[25:0] & `EXT_RESERVED) == 26'h0;
  endproperty
  a_ext_rsv: assert property (p_ext_rsv) else $error("reserved ext");
  property p_base; isa |=> csr_rdata_o[`EXT_BIT_I] != csr_rdata_o[`EXT_BIT_E];
  endproperty
  a_base: assert property (p_base) else $error("base letter");
  property p_isa_ok; isa |-> !csr_illegal_o; endproperty
  a_isa_ok: assert property (p_isa_ok) else $error("isa fault");
  property p_mfr_rd; mfr && pm && csr_op_i != ident_csr_pkg::OP_WRITE
    |=> csr_rdata_o == `MFR_ID_VALUE; endproperty
  a_mfr_rd: assert property (p_mfr_rd) else $error("mfr value");
  property p_mfr_wr; mfr && csr_op_i == ident_csr_pkg::OP_WRITE
    |-> csr_illegal_o; endproperty
  a_mfr_wr: assert property (p_mfr_wr) else $error("mfr write");
  property p_pp; pp |=> csr_rdata_o[12] == csr_rdata_o[11]; endproperty
  a_pp: assert property (p_pp) else $error("pp legal");
  property p_idle; !csr_req_i |=> csr_rdata_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle data");
  c_isa: cover property (isa);
  c_pp: cover property (pp && csr_op_i == ident_csr_pkg::OP_WRITE);
  c_mfr: cover property (mfr && csr_illegal_o);
endmodule : ident_csr_bank_properties

// >>> verification/tb_ident_csr_bank.sv
// Directed bench for the identification register block.
`timescale 1ns/1ps
`include "ident_csr_params.svh"

module tb_ident_csr_bank;
  // ****************************************************************
  // Stimulus and checking
  // ****************************************************************
  localparam ident_csr_pkg::csr_op_t WR = ident_csr_pkg::OP_WRITE;
  localparam ident_csr_pkg::csr_op_t ST = ident_csr_pkg::OP_SET;
  localparam ident_csr_pkg::csr_op_t RD = ident_csr_pkg::OP_CLEAR;
  localparam ident_csr_pkg::priv_t   PM = ident_csr_pkg::PRIV_M;
  localparam logic [25:0] EXT = (26'h0001105 & `EXT_OTHER_STD) | 26'h0100100;
  localparam logic [31:0] ISA = {`WIDTH_CODE_32, 4'h0, EXT};
  logic                   core_clk_i  = 1'b0;
  logic                   rst_i       = 1'b1;
  logic                   csr_req_i   = 1'b0;
  logic [`ADDR_W-1:0]     csr_addr_i  = 12'h000;
  ident_csr_pkg::csr_op_t csr_op_i    = RD;
  logic [`NRW-1:0]        csr_wdata_i = 32'h0;
  ident_csr_pkg::priv_t   cur_priv_i  = PM;
  logic [`NRW-1:0]        csr_rdata_o;
  logic                   csr_illegal_o;
  ident_csr_pkg::priv_t   reset_priv_o;
  int                     errors      = 0;
  int                     tests_run   = 0;
  int                     cycles      = 0;
  logic [31:0]            rd;
  logic                   il;
  ident_csr_pkg::csr_op_t ops [7] = '{WR, WR, WR, WR, WR, ST, RD};
  logic [31:0] pw [7] = '{32'h1800, 32'h1000, 32'h1000, 32'h0, 32'h800,
                          32'h1800, 32'h1800};
  logic [31:0] pr [7] = '{32'h1800, 32'h1800, 32'h1800, 32'h0, 32'h0,
                          32'h1800, 32'h0};

  ident_csr_bank dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .csr_req_i(csr_req_i), .csr_addr_i(csr_addr_i), .csr_op_i(csr_op_i),
    .csr_wdata_i(csr_wdata_i), .cur_priv_i(cur_priv_i),
    .csr_rdata_o(csr_rdata_o), .csr_illegal_o(csr_illegal_o),
    .reset_priv_o(reset_priv_o));

  always #2.5 core_clk_i = ~core_clk_i;

  // The ceiling is far above the roughly 70 cycles the sequence needs.
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic acc(input logic [11:0] a, input ident_csr_pkg::csr_op_t op,
                     input logic [31:0] wd, input ident_csr_pkg::priv_t pv);
    @(posedge core_clk_i);
    csr_req_i   <= 1'b1;
    csr_addr_i  <= a;
    csr_op_i    <= op;
    csr_wdata_i <= wd;
    cur_priv_i  <= pv;
    #1 il = csr_illegal_o;
    @(posedge core_clk_i);
    csr_req_i <= 1'b0;
    #1 rd = csr_rdata_o;
  endtask : acc

  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1 chk("reset_priv", {30'h0, reset_priv_o}, {30'h0, PM});
    acc(`ADDR_ISA_REPORT, RD, 32'h0, PM);
    chk("isa", rd, ISA);
    for (int i = 4; i < 7; i++) begin
      acc(`ADDR_ISA_REPORT, ops[i], 32'hFFFF_FFFF, PM);
      chk("isa_wr_fault", {31'h0, il}, 32'h0);
      acc(`ADDR_ISA_REPORT, RD, 32'h0, PM);
      chk("isa_after_wr", rd, ISA);
    end
    acc(`ADDR_MFR_ID, RD, 32'h0, PM);
    chk("mfr", rd, `MFR_ID_VALUE);
    acc(`ADDR_MFR_ID, WR, 32'h1234_5678, PM);
    chk("mfr_wr_fault", {31'h0, il}, 32'h1);
    acc(`ADDR_STATUS_M, RD, 32'h0, PM);
    chk("pp_reset", rd & 32'h1800, 32'h1800);
    for (int i = 0; i < 7; i++) begin
      acc(`ADDR_STATUS_M, ops[i], pw[i], PM);
      chk("pp_wr_fault", {31'h0, il}, 32'h0);
      acc(`ADDR_STATUS_M, RD, 32'h0, PM);
      chk("pp_read", rd & 32'h1800, pr[i]);
    end
    acc(`ADDR_SCRATCH_M, WR, 32'hA5A5_5A5A, PM);
    acc(`ADDR_SCRATCH_M, RD, 32'h0, PM);
    chk("scratch", rd, 32'hA5A5_5A5A);
    acc(`ADDR_SCRATCH_M, RD, 32'h0, ident_csr_pkg::PRIV_U);
    chk("low_priv_fault", {31'h0, il}, 32'h1);
    acc(12'h7C0, RD, 32'h0, PM);
    chk("unmapped_fault", {31'h0, il}, 32'h1);
    // A reset in mid-run must bring the stored field from U back to M.
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    acc(`ADDR_STATUS_M, RD, 32'h0, PM);
    chk("pp_after_rst", rd & 32'h1800, 32'h1800);
    acc(`ADDR_SCRATCH_M, RD, 32'h0, PM);
    chk("scratch_rst", rd, 32'h0);
    finish_test();
  end
endmodule : tb_ident_csr_bank

bind ident_csr_bank ident_csr_bank_properties chk_i (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .csr_req_i(csr_req_i), .csr_addr_i(csr_addr_i),
  .csr_op_i(csr_op_i), .csr_wdata_i(csr_wdata_i), .cur_priv_i(cur_priv_i),
  .csr_rdata_o(csr_rdata_o), .csr_illegal_o(csr_illegal_o),
  .reset_priv_o(reset_priv_o));
